// >>> hdl/ewp_core.sv
// Write enable latch, status register and write protection of a serial EEPROM.
`default_nettype none
module ewp_core #(
  parameter int ADDR_W = 15,
  parameter int WR_CYC = ewp_pkg::T_WRITE_US * 1000 / ewp_pkg::CLK_PERIOD_NS,
  parameter logic [7:0] NV_INIT = ewp_pkg::NV_RESET
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire ewp_pkg::ewp_pins_s pins,
  output logic so,
  output logic so_oe,
  output logic arr_wr_go,
  output logic arr_rd_go,
  output logic [15:0] arr_addr,
  output ewp_pkg::ewp_stat_s status
);
  import ewp_pkg::*;

  localparam int CW = $clog2(WR_CYC + 1);
  localparam logic [CW-1:0] WR_LOAD = CW'(WR_CYC);
  localparam ewp_stat_s NV_IMG = ewp_stat_s'(NV_INIT);

  logic [3:0] pin_q;
  ewp_pins_s pq;
  ewp_pins_s prev_ff;
  ewp_state_e st_ff;
  ewp_state_e nxt_st;
  ewp_state_e dec_st;
  ewp_stat_s nvd_ff;
  ewp_stat_s stat;
  ewp_stat_s status_ff;
  logic [2:0] bitc_ff;
  logic [2:0] obit_ff;
  logic [1:0] bytec_ff;
  logic [7:0] sh_ff;
  logic [7:0] so_sh_ff;
  logic [15:0] addr_ff;
  logic [CW-1:0] busy_cnt_ff;
  logic got_ff;
  logic latch_ff;
  logic pen_ff;
  logic [1:0] bp_ff;
  logic so_ff;
  logic so_oe_ff;
  logic wr_go_ff;
  logic rd_go_ff;

  ewp_pin_sync #(
    .W(4),
    .RST(PIN_RESET)
  ) u_ewp_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(pins),
    .dout(pin_q)
  );
  assign pq = ewp_pins_s'(pin_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_ff <= ewp_pins_s'(PIN_RESET);
    end else begin
      prev_ff <= pq;
    end
  end

  // Edge decode on the filtered pins; serial clock counts only while selected.
  wire logic cs_fall = prev_ff.cs_n & ~pq.cs_n;
  wire logic cs_rise = ~prev_ff.cs_n & pq.cs_n;
  wire logic sck_rise = ~prev_ff.sck & pq.sck & ~pq.cs_n;
  wire logic sck_fall = prev_ff.sck & ~pq.sck & ~pq.cs_n;
  wire logic byte_done = sck_rise & (bitc_ff == BIT_LAST);
  wire logic [7:0] byte_in = {sh_ff[6:0], pq.si};
  wire logic busy = busy_cnt_ff != '0;
  wire logic hw_prot = pen_ff & ~pq.wp_n;
  wire logic [1:0] top2 = addr_ff[ADDR_W-1 -: 2];
  wire logic addr_prot = (bp_ff == BP_ALL)
    | ((bp_ff == BP_HALF) & top2[1])
    | ((bp_ff == BP_QUARTER) & (top2 == QUARTER_TOP));
  wire logic addr_last = byte_done & (bytec_ff == ADDR_BYTE_LAST);

  // Only read-status is honoured while the internal write runs.
  assign dec_st = (byte_in == READ_STATUS_CMD) ? ST_READ_STATUS :
    busy ? ST_SKIP :
    (byte_in == SET_LATCH_CMD) ? ST_SET_LATCH :
    (byte_in == CLEAR_LATCH_CMD) ? ST_CLEAR_LATCH :
    (byte_in == WRITE_STATUS_CMD) ? ST_WRITE_STATUS :
    (byte_in == WRITE_ARRAY_CMD) ? ST_WRITE_ADDR :
    (byte_in == READ_ARRAY_CMD) ? ST_READ_ADDR : ST_SKIP;

  // Commands act on the select rise only; a stray clock moves set, clear and status write to skip, and leaves an array write on a partial byte.
  wire logic set_go = cs_rise & (st_ff == ST_SET_LATCH);
  wire logic clr_go = cs_rise & (st_ff == ST_CLEAR_LATCH);
  wire logic write_status_cmd_try = cs_rise & (st_ff == ST_WRITE_STATUS_END);
  wire logic write_status_cmd_go = write_status_cmd_try & latch_ff & ~hw_prot;
  wire logic wr_try = cs_rise & (st_ff == ST_WRITE_DATA) & got_ff & (bitc_ff == '0);
  wire logic wr_go = wr_try & latch_ff & ~addr_prot;

  assign stat = '{
    protect_pin_enable: pen_ff,
    dont_care: STATUS_DONT_CARE,
    block_protect_hi: bp_ff[1],
    block_protect_lo: bp_ff[0],
    latch_flag: latch_ff,
    busy_flag: busy
  };

  always_comb begin
    nxt_st = st_ff;
    if (cs_rise) begin
      nxt_st = ST_IDLE;
    end else if (cs_fall) begin
      nxt_st = ST_CMD;
    end else if (sck_rise) begin
      case (st_ff)
        ST_CMD: begin
          if (byte_done) begin
            nxt_st = dec_st;
          end
        end
        ST_SET_LATCH, ST_CLEAR_LATCH, ST_WRITE_STATUS_END: begin
          nxt_st = ST_SKIP;
        end
        ST_WRITE_STATUS: begin
          if (byte_done) begin
            nxt_st = ST_WRITE_STATUS_END;
          end
        end
        ST_WRITE_ADDR: begin
          if (addr_last) begin
            nxt_st = ST_WRITE_DATA;
          end
        end
        ST_READ_ADDR: begin
          if (addr_last) begin
            nxt_st = ST_SKIP;
          end
        end
        default: begin
          nxt_st = st_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= ST_IDLE;
      bitc_ff <= '0;
      bytec_ff <= '0;
      sh_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      if (cs_fall) begin
        bitc_ff <= '0;
        bytec_ff <= '0;
      end else if (sck_rise) begin
        bitc_ff <= bitc_ff + 3'h1;
        sh_ff <= byte_in;
        if (byte_done && (st_ff == ST_WRITE_ADDR || st_ff == ST_READ_ADDR)) begin
          bytec_ff <= bytec_ff + 2'h1;
        end
      end
    end
  end

  // Address shift and data-byte tracking for array commands.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_ff <= '0;
      got_ff <= 1'b0;
      nvd_ff <= '0;
    end else begin
      if (cs_fall) begin
        got_ff <= 1'b0;
      end else if (byte_done && st_ff == ST_WRITE_DATA) begin
        got_ff <= 1'b1;
      end
      if (sck_rise && (st_ff == ST_WRITE_ADDR || st_ff == ST_READ_ADDR)) begin
        addr_ff <= {addr_ff[14:0], pq.si};
      end
      if (byte_done && st_ff == ST_WRITE_STATUS) begin
        nvd_ff <= ewp_stat_s'(byte_in);
      end
    end
  end

  // The latch only changes on a select rise, so a write in the same
  // selection as the set command still sees it clear.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_ff <= 1'b0;
    end else if (set_go) begin
      latch_ff <= 1'b1;
    end else if (clr_go || write_status_cmd_go || wr_go) begin
      latch_ff <= 1'b0;
    end
  end

  // Reset loads the power-up image of the nonvolatile cells; a status write made
  // before a later reset is not kept, so set NV_INIT to the image the cells hold.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pen_ff <= NV_IMG.protect_pin_enable;
      bp_ff <= {NV_IMG.block_protect_hi, NV_IMG.block_protect_lo};
    end else if (write_status_cmd_go) begin
      pen_ff <= nvd_ff.protect_pin_enable;
      bp_ff <= {nvd_ff.block_protect_hi, nvd_ff.block_protect_lo};
    end
  end

  // The write decision is taken once at start; the pin is not looked at again.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_cnt_ff <= '0;
    end else if (write_status_cmd_go || wr_go) begin
      busy_cnt_ff <= WR_LOAD;
    end else if (busy) begin
      busy_cnt_ff <= busy_cnt_ff - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Status shifts out after falling clocks and reloads each byte so busy is live.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      so_sh_ff <= '0;
      obit_ff <= '0;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      if (byte_done && st_ff == ST_CMD && byte_in == READ_STATUS_CMD) begin
        so_sh_ff <= stat;
        obit_ff <= '0;
      end else if (sck_fall && st_ff == ST_READ_STATUS) begin
        so_ff <= so_sh_ff[7];
        obit_ff <= obit_ff + 3'h1;
        so_sh_ff <= (obit_ff == BIT_LAST) ? stat : {so_sh_ff[6:0], 1'b0};
      end
      if (st_ff != ST_READ_STATUS) begin
        so_oe_ff <= 1'b0;
      end else if (sck_fall) begin
        so_oe_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_go_ff <= 1'b0;
      rd_go_ff <= 1'b0;
      status_ff <= '0;
    end else begin
      wr_go_ff <= wr_go;
      rd_go_ff <= addr_last & (st_ff == ST_READ_ADDR);
      status_ff <= stat;
    end
  end

  assign so = so_ff;
  assign so_oe = so_oe_ff;
  assign arr_wr_go = wr_go_ff;
  assign arr_rd_go = rd_go_ff;
  assign arr_addr = addr_ff;
  assign status = status_ff;

  // Any internal write, array or status, must start from a set latch.
  property p_wr_needs_latch;
    @(posedge clk_sys) disable iff (rst)
    $rose(busy) |-> $past(latch_ff);
  endproperty
  a_wr_needs_latch: assert property (p_wr_needs_latch) else $error("write without latch");

  property p_set_latch;
    @(posedge clk_sys) disable iff (rst)
    set_go |=> latch_ff ##1 status_ff.latch_flag;
  endproperty
  a_set_latch: assert property (p_set_latch) else $error("set command missed latch");

  property p_clear_after_write;
    @(posedge clk_sys) disable iff (rst)
    (wr_go || write_status_cmd_go || clr_go) |=> !latch_ff;
  endproperty
  a_clear_after_write: assert property (p_clear_after_write) else $error("latch not cleared");

  property p_status_fields;
    @(posedge clk_sys) disable iff (rst)
    ##1 (status_ff.dont_care == STATUS_DONT_CARE)
      && (status_ff.latch_flag == $past(latch_ff))
      && (status_ff.busy_flag == $past(busy));
  endproperty
  a_status_fields: assert property (p_status_fields) else $error("status byte wrong");

  property p_busy_after_start;
    @(posedge clk_sys) disable iff (rst)
    (write_status_cmd_go || wr_go) |=> busy[*8];
  endproperty
  a_busy_after_start: assert property (p_busy_after_start) else $error("busy too short");

  property p_bp_only_write_status_cmd;
    @(posedge clk_sys) disable iff (rst)
    ($changed(bp_ff) || $changed(pen_ff)) |-> $past(write_status_cmd_go);
  endproperty
  a_bp_only_write_status_cmd: assert property (p_bp_only_write_status_cmd) else $error("protect bits moved");

  property p_hw_prot_blocks;
    @(posedge clk_sys) disable iff (rst)
    (write_status_cmd_try && hw_prot) |=> $stable(bp_ff) && $stable(pen_ff) && !busy;
  endproperty
  a_hw_prot_blocks: assert property (p_hw_prot_blocks) else $error("protected status written");

  property p_busy_ignores;
    @(posedge clk_sys) disable iff (rst)
    (busy && byte_done && st_ff == ST_CMD) |=> st_ff inside {ST_SKIP, ST_READ_STATUS};
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("command taken while busy");

  property p_idle_quiet;
    @(posedge clk_sys) disable iff (rst)
    (st_ff == ST_IDLE) |=> !so_oe_ff;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output driven while idle");
endmodule
`default_nettype wire

// >>> hdl/ewp_pkg.sv
// Shared constants and types of the EEPROM write-protect and status block.
`default_nettype none
package ewp_pkg;
  // Command opcodes, shifted in most significant bit first.
  localparam logic [7:0] SET_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_LATCH_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] WRITE_ARRAY_CMD = 8'h02;
  localparam logic [7:0] READ_ARRAY_CMD = 8'h03;

  // Block-protect codes and the top-two-address-bit value of the upper quarter.
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [1:0] QUARTER_TOP = 2'h3;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_BYTE_LAST = 2'h1;
  localparam logic [2:0] STATUS_DONT_CARE = 3'h0;
  localparam logic [7:0] NV_RESET = 8'h00;

  // Pin synchroniser reset image: select reads low so a pin held low at
  // power-up never looks like a falling edge; write-protect reads high.
  localparam logic [3:0] PIN_RESET = 4'h1;

  // Self-timed nonvolatile write, longest time, and the system clock period.
  localparam int T_WRITE_US = 6000;
  localparam int CLK_PERIOD_NS = 20;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } ewp_pins_s;

  typedef struct packed {
    logic protect_pin_enable;
    logic [2:0] dont_care;
    logic block_protect_hi;
    logic block_protect_lo;
    logic latch_flag;
    logic busy_flag;
  } ewp_stat_s;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CMD,
    ST_SET_LATCH,
    ST_CLEAR_LATCH,
    ST_READ_STATUS,
    ST_WRITE_STATUS,
    ST_WRITE_STATUS_END,
    ST_WRITE_ADDR,
    ST_WRITE_DATA,
    ST_READ_ADDR,
    ST_SKIP
  } ewp_state_e;
endpackage
`default_nettype wire

// >>> hdl/ewp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
`default_nettype none
module ewp_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import ewp_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic stable_ff;
      // The first stage feeds only the second; the filter looks at stages two and three.
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          s1_ff <= RST[i];
          s2_ff <= RST[i];
          s3_ff <= RST[i];
          stable_ff <= RST[i];
        end else begin
          s1_ff <= din[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            stable_ff <= s3_ff;
          end
        end
      end
      assign dout[i] = stable_ff;
    end
  endgenerate
endmodule
`default_nettype wire

// >>> verif/ewp_spi_host.sv
// SPI host model that drives select, clock and data into the protect block.
`default_nettype none
module ewp_spi_host #(
  parameter int HALF = 5
) (
  input wire logic clk_sys,
  input wire logic so,
  input wire logic so_oe,
  output var logic cs_n,
  output var logic sck,
  output var logic si
);
  timeunit 1ns;
  timeprecision 1ns;

  // Select idles high and the serial clock stands low outside frames.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Sends nbits of dat and gathers the last eight bits seen on so at the clock rises.
  // Select rises right after the last bit, so a write command is taken whole.
  task automatic xfer(input logic [31:0] dat, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_sys) cs_n <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      repeat (HALF) @(posedge clk_sys);
      si <= dat[i];
      repeat (HALF) @(posedge clk_sys);
      sck <= 1'b1;
      rd = {rd[6:0], (so_oe === 1'b1) ? so : 1'bx};
      repeat (HALF) @(posedge clk_sys);
      sck <= 1'b0;
    end
    repeat (HALF) @(posedge clk_sys);
    cs_n <= 1'b1;
    // A released data line must not keep looking like the last bit.
    si <= ~si;
    repeat (3 * HALF) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_ewp_core.sv
// Self-checking bench of the write-protect and status block.
`default_nettype none
module tb_ewp_core;
  timeunit 1ns;
  timeprecision 1ns;
  import ewp_pkg::*;
  // Long enough that a status read and an array read both fit inside one write.
  localparam int WR = 1200;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic cs_n, sck, si, so, so_oe, arr_wr_go, arr_rd_go;
  logic [15:0] arr_addr, last_addr;
  logic [7:0] rd;
  ewp_stat_s status;
  ewp_pins_s pins;
  int error_cnt = 0;
  int n_tests = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  assign pins = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n};

  ewp_core #(.ADDR_W(15), .WR_CYC(WR), .NV_INIT(NV_RESET)) u_ewp_core (
    .clk_sys(clk_sys), .rst(rst), .pins(pins), .so(so), .so_oe(so_oe),
    .arr_wr_go(arr_wr_go), .arr_rd_go(arr_rd_go), .arr_addr(arr_addr), .status(status));
  ewp_spi_host u_ewp_spi_host (
    .clk_sys(clk_sys), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (arr_wr_go === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      last_addr <= arr_addr;
    end
    if (arr_rd_go === 1'b1) rd_cnt <= rd_cnt + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [15:0] sb(input logic [7:0] v);
    return {8'h00, v[7], STATUS_DONT_CARE, v[3:0]};
  endfunction

  task automatic cmd(input logic [31:0] d, input int n);
    u_ewp_spi_host.xfer(d, n, rd);
  endtask

  task automatic read_status_cmd(input logic [7:0] exp);
    cmd({16'h0000, READ_STATUS_CMD, 8'h00}, 16);
    check({8'h00, rd}, sb(exp));
    check({8'h00, status}, sb(exp));
  endtask

  // Busy is already up when a command returns; used is the number of clocks of
  // other traffic sent since then, by which the remaining write time is shorter.
  task automatic wait_idle(input int used);
    int k;
    k = 0;
    while (status.busy_flag !== 1'b0 && k < 3 * WR) begin
      @(posedge clk_sys);
      k++;
    end
    check({15'h0, k > WR - 40 - used && k <= WR - used}, 16'h0001);
  endtask

  task automatic try_write(input logic [15:0] a, input logic ok, input logic [7:0] st);
    int c0;
    cmd({24'h0, SET_LATCH_CMD}, 8);
    c0 = wr_cnt;
    cmd({WRITE_ARRAY_CMD, a, 8'hA5}, 32);
    check(16'(wr_cnt - c0), {15'h0, ok});
    if (ok) begin
      check(last_addr, a);
      check({8'h00, status}, sb({st[7:2], 2'b01}));
      wait_idle(0);
    end else begin
      check({8'h00, status}, sb({st[7:2], 2'b10}));
      cmd({24'h0, CLEAR_LATCH_CMD}, 8);
      check({8'h00, status}, sb({st[7:2], 2'b00}));
    end
  endtask

  initial begin
    int c0;
    logic ok;
    logic [15:0] adr [6];
    adr = '{16'h0000, 16'h3FFF, 16'h4000, 16'h5FFF, 16'h6000, 16'h7FFF};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check({8'h00, status}, sb(NV_RESET & 8'h8C));
    check({15'h0, so_oe}, 16'h0000);
    read_status_cmd(NV_RESET & 8'h8C);
    c0 = wr_cnt;
    cmd({WRITE_ARRAY_CMD, 16'h0000, 8'h5A}, 32);
    check(16'(wr_cnt - c0), 16'h0000);
    cmd({24'h0, SET_LATCH_CMD}, 8);
    check({8'h00, status}, 16'h0002);
    cmd({24'h0, CLEAR_LATCH_CMD}, 8);
    check({8'h00, status}, 16'h0000);
    cmd({16'h0, SET_LATCH_CMD, WRITE_ARRAY_CMD}, 16);
    check({8'h00, status}, 16'h0000);
    for (int b = 0; b < 4; b++) begin
      cmd({24'h0, SET_LATCH_CMD}, 8);
      cmd({16'h0, WRITE_STATUS_CMD, 4'h7, b[1:0], 2'b00}, 16);
      check({8'h00, status}, sb({4'h0, b[1:0], 2'b01}));
      wait_idle(0);
      read_status_cmd({4'h0, b[1:0], 2'b00});
      for (int j = 0; j < 6; j++) begin
        ok = !(b == 3 || (b == 2 && adr[j] >= 16'h4000) || (b == 1 && adr[j] >= 16'h6000));
        try_write(adr[j], ok, {4'h0, b[1:0], 2'b00});
      end
    end
    cmd({24'h0, SET_LATCH_CMD}, 8);
    cmd({16'h0, WRITE_STATUS_CMD, 8'h00}, 16);
    wait_idle(0);
    // Array write, then status and array reads while it is still in progress.
    cmd({24'h0, SET_LATCH_CMD}, 8);
    cmd({WRITE_ARRAY_CMD, 16'h1234, 8'h11}, 32);
    read_status_cmd(8'h01);
    c0 = rd_cnt;
    cmd({8'h00, READ_ARRAY_CMD, 16'h1234}, 24);
    check(16'(rd_cnt - c0), 16'h0000);
    // The two frames of 16 and 24 bits take 15 clocks a bit plus 21 of framing each.
    wait_idle(642);
    cmd({8'h00, READ_ARRAY_CMD, 16'h1234}, 24);
    check(16'(rd_cnt - c0), 16'h0001);
    // The protect pin falls after the status write has started.
    cmd({24'h0, SET_LATCH_CMD}, 8);
    cmd({16'h0, WRITE_STATUS_CMD, 8'h80}, 16);
    wp_n <= 1'b0;
    wait_idle(0);
    read_status_cmd(8'h80);
    cmd({24'h0, SET_LATCH_CMD}, 8);
    cmd({16'h0, WRITE_STATUS_CMD, 8'h0C}, 16);
    check({8'h00, status}, sb(8'h82));
    try_write(16'h7FFF, 1'b1, 8'h80);
    @(posedge clk_sys) wp_n <= 1'b1;
    cmd({24'h0, SET_LATCH_CMD}, 8);
    cmd({16'h0, WRITE_STATUS_CMD, 8'h00}, 16);
    wait_idle(0);
    read_status_cmd(8'h00);
    @(posedge clk_sys) wp_n <= 1'b0;
    cmd({24'h0, SET_LATCH_CMD}, 8);
    cmd({16'h0, WRITE_STATUS_CMD, 8'h04}, 16);
    wait_idle(0);
    read_status_cmd(8'h04);
    // Power-up again in mid-run: the latch drops and the output stays off.
    cmd({24'h0, SET_LATCH_CMD}, 8);
    check({8'h00, status}, sb(8'h06));
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check({8'h00, status}, sb(NV_RESET & 8'h8C));
    check({15'h0, so_oe}, 16'h0000);
    read_status_cmd(NV_RESET & 8'h8C);
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
